// >>> dcpwm_pkg.sv
// constants for the dual channel pwm unit
package dcpwm_pkg;

	// ----------------------------------------
	// register indices (byte address = index * 4)
	// ----------------------------------------
	localparam logic [9:0] IDX_DUTY [2] = '{10'h314, 10'h318};
	localparam logic [9:0] IDX_CTRL [2] = '{10'h316, 10'h31A};
	localparam logic [9:0] IDX_PERIOD   = 10'h31C;
	localparam logic [9:0] IDX_TCTL     = 10'h31D;
	localparam logic [9:0] IDX_TSTAT    = 10'h31E;
	localparam logic [9:0] IDX_PINCTL   = 10'h31F;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CTL_EN_BIT     = 7;
	localparam int CTL_OUT_BIT    = 5;
	localparam int CTL_POL_BIT    = 4;
	localparam int DUTY_HI_LSB    = 8;
	localparam int DUTY_LO_LSB    = 6;
	localparam int TCTL_ON_BIT    = 2;
	localparam int TSTAT_FLAG_BIT = 0;
	localparam int TSTAT_CNT_LSB  = 8;
	localparam int PIN_DIR_LSB    = 0;
	localparam int PIN_LAT_LSB    = 2;
	localparam int PIN_ROUTE_LSB  = 4;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] PERIOD_RST  = 8'hFF;
	localparam logic [1:0] PRESC_RST   = 2'h0;
	localparam logic [1:0] PIN_DIR_RST = 2'h3;
	localparam logic [1:0] PIN_LAT_RST = 2'h0;
	localparam logic [1:0] ROUTE_RST   = 2'h0;

	// ----------------------------------------
	// time base: last count of prescaler for 1:1, 1:4, 1:16, 1:64
	// ----------------------------------------
	localparam logic [5:0] PRESC_LAST [4] = '{6'h00, 6'h03, 6'h0F, 6'h3F};
	localparam logic [1:0] SUB_MAX        = 2'h3;

endpackage

// >>> dcpwm_chan.sv
// one pwm channel: control, double-buffered duty and output level
`timescale 1ns/1ns
module dcpwm_chan (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// time base
	input  wire logic        sleep,
	input  wire logic        restart,
	input  wire logic [9:0]  base,
	input  wire logic [7:0]  period,
	// register writes
	input  wire logic [15:0] wdata,
	input  wire logic [1:0]  duty_we,
	input  wire logic        ctl_we,
	// read back and waveform
	output logic      [15:0] duty_rd,
	output logic      [7:0]  ctl_rd,
	output logic             level
);
	import dcpwm_pkg::*;

	logic       en_r;
	logic       pol_r;
	logic       raw_r;
	logic [7:0] hi_r;
	logic [1:0] lo_r;
	logic [9:0] buf_r;
	logic [9:0] duty_now;
	logic       full;

	assign duty_now = {hi_r, lo_r};
	// a compare value beyond the last count of the period can never match
	assign full  = {1'b0, buf_r} >= ({1'b0, period, 2'b00} + 11'h004);
	assign level = raw_r ^ pol_r;
	assign duty_rd = {hi_r, lo_r, 6'h00};
	assign ctl_rd  = {en_r, 1'b0, level, pol_r, 4'h0};

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			en_r  <= 1'b0;
			pol_r <= 1'b0;
		end else if (ctl_we) begin
			en_r  <= wdata[CTL_EN_BIT];
			pol_r <= wdata[CTL_POL_BIT];
		end
	end

	// duty survives rst on purpose; only power-up leaves it unknown
	always_ff @(posedge clk_sys) begin
		if (duty_we[1])
			hi_r <= wdata[DUTY_HI_LSB +: 8];
		if (duty_we[0])
			lo_r <= wdata[DUTY_LO_LSB +: 2];
	end

	always_ff @(posedge clk_sys) begin
		if (restart)
			buf_r <= duty_now;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			raw_r <= 1'b0;
		end else if (sleep) begin
			raw_r <= raw_r;
		end else if (!en_r) begin
			raw_r <= 1'b0;
		end else if (restart) begin
			raw_r <= (duty_now != 10'h000);
		end else if (base == buf_r && !full) begin
			raw_r <= 1'b0;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	chk_restart_sets: assert property (restart && en_r && duty_now != 10'h000 |=> raw_r)
		else $error("output not set at restart");
	chk_zero_duty: assert property (restart && en_r && duty_now == 10'h000 |=> !raw_r)
		else $error("zero duty went active");
	chk_buffer_hold: assert property (!restart |=> $stable(buf_r))
		else $error("compare buffer moved between restarts");
	chk_full_duty: assert property (en_r && raw_r && full && !restart && !ctl_we |=> raw_r)
		else $error("full duty output cleared");
	chk_enable_write: assert property (ctl_we |=> en_r == $past(wdata[CTL_EN_BIT]))
		else $error("enable bit not written");
	chk_pol_write: assert property (ctl_we |=> pol_r == $past(wdata[CTL_POL_BIT]))
		else $error("polarity bit not written");
	chk_disabled_idle: assert property (!en_r && !sleep |=> level == pol_r)
		else $error("disabled channel not idle");
	chk_duty_kept: assert property (@(posedge clk_sys) disable iff (1'b0) rst |=> $stable(hi_r))
		else $error("duty changed by reset");
endmodule

// >>> dcpwm_top.sv
// dual channel pwm unit: apb registers, shared time base, pin mux
//
// Summary of operation
// - sleep stops timer and freezes channel state
// - driven pins hold their level during sleep
// - timer resumes from held count after wake
// - waveform rate follows the system clock
// - reset restores controls, pins become inputs
// - waveform replaces port latch when routed
// - control bit 7 enables the channel
// - control bit 5 reads output level
// - control bit 4 inverts the output
// - duty high byte 15:8, low bits 7:6
// - duty register untouched by ordinary reset
// - set at restart, clear on duty match
// - duty at or past period never clears
// - duty buffered, taken at period restart
// - zero duty stays inactive at restart
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
module dcpwm_top #(
	parameter int N_CH = 2
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// power state
	input  wire logic        sleep,
	// port pins
	output logic      [1:0]  pin_out,
	output logic      [1:0]  pin_oe,
	// waveform to on-chip peripherals
	output logic      [1:0]  wave_out
);
	import dcpwm_pkg::*;

	// ----------------------------------------
	// elaboration check
	// ----------------------------------------
	if (N_CH != 2) begin : g_bad_ch
		$error("register map serves exactly two channels");
	end

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic              pready_r;
	logic              pslverr_r;
	logic       [31:0] prdata_r;
	logic              acc;
	logic              done;
	logic              we;
	logic              aligned;
	logic       [9:0]  idx;
	logic              hit;
	logic       [15:0] rd_val;

	logic       [7:0]  period_r;
	logic              on_r;
	logic       [1:0]  presc_sel_r;
	logic       [5:0]  presc_r;
	logic       [1:0]  sub_r;
	logic       [7:0]  cnt_r;
	logic              flag_r;
	logic              tick;
	logic              restart;
	logic       [9:0]  base;
	logic       [9:0]  base_nxt;

	logic       [1:0]  dir_r;
	logic       [1:0]  lat_r;
	logic       [1:0]  route_r;
	logic       [1:0]  pin_out_r;
	logic       [1:0]  pin_oe_r;
	logic       [1:0]  wave_r;

	logic       [15:0] duty_rd [N_CH];
	logic       [7:0]  ctl_rd  [N_CH];
	logic       [1:0]  level;

	// ----------------------------------------
	// apb handshake
	// ----------------------------------------
	assign acc     = psel && penable;
	assign done    = acc && pready_r;
	assign idx     = paddr[11:2];
	assign aligned = (paddr[1:0] == 2'b00);
	// the cpu is halted in sleep, so stray writes then are dropped
	assign we      = done && pwrite && hit && !sleep;

	// one wait state: pready comes from a flop, as every output does
	always_ff @(posedge clk_sys) begin
		if (rst)
			pready_r <= 1'b0;
		else
			pready_r <= acc && !pready_r;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (acc && !pready_r) begin
			prdata_r  <= pwrite ? 32'h0000_0000 : {16'h0000, rd_val};
			pslverr_r <= !hit;
		end else begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end
	end

	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;

	// ----------------------------------------
	// address decode and read mux
	// ----------------------------------------
	always_comb begin
		hit    = 1'b0;
		rd_val = 16'h0000;
		if (aligned) begin
			for (int i = 0; i < N_CH; i++) begin
				if (idx == IDX_DUTY[i]) begin
					hit    = 1'b1;
					rd_val = duty_rd[i];
				end
				if (idx == IDX_CTRL[i]) begin
					hit    = 1'b1;
					rd_val = {8'h00, ctl_rd[i]};
				end
			end
			if (idx == IDX_PERIOD) begin
				hit    = 1'b1;
				rd_val = {8'h00, period_r};
			end
			if (idx == IDX_TCTL) begin
				hit    = 1'b1;
				rd_val = {13'h0000, on_r, presc_sel_r};
			end
			if (idx == IDX_TSTAT) begin
				hit    = 1'b1;
				rd_val = {cnt_r, 7'h00, flag_r};
			end
			if (idx == IDX_PINCTL) begin
				hit    = 1'b1;
				rd_val = {10'h000, route_r, lat_r, dir_r};
			end
		end
	end

	// ----------------------------------------
	// timer configuration
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			period_r <= PERIOD_RST;
		end else if (we && idx == IDX_PERIOD && pstrb[0]) begin
			period_r <= pwdata[7:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			on_r        <= 1'b0;
			presc_sel_r <= PRESC_RST;
		end else if (we && idx == IDX_TCTL && pstrb[0]) begin
			on_r        <= pwdata[TCTL_ON_BIT];
			presc_sel_r <= pwdata[1:0];
		end
	end

	// ----------------------------------------
	// shared time base
	// ----------------------------------------
	// the two low bits count prescaler ticks, so the rate tracks clk_sys
	assign tick    = on_r && !sleep && (presc_r >= PRESC_LAST[presc_sel_r]);
	assign restart = tick && (sub_r == SUB_MAX) && (cnt_r == period_r);
	assign base    = {cnt_r, sub_r};
	// channels compare against the coming base, so a clear lands on the first clock of the match
	assign base_nxt = restart ? 10'h000 : (tick ? base + 10'h001 : base);

	always_ff @(posedge clk_sys) begin
		if (rst)
			presc_r <= 6'h00;
		else if (sleep)
			presc_r <= presc_r;
		else if (!on_r || tick)
			presc_r <= 6'h00;
		else
			presc_r <= presc_r + 6'h01;
	end

	// count is never reloaded on wake; it simply carries on
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sub_r <= 2'h0;
			cnt_r <= 8'h00;
		end else if (tick) begin
			sub_r <= sub_r + 2'h1;
			if (sub_r == SUB_MAX)
				cnt_r <= (cnt_r == period_r) ? 8'h00 : cnt_r + 8'h01;
		end
	end

	// overflow flag: a restart in the clearing cycle still sets it
	always_ff @(posedge clk_sys) begin
		if (rst)
			flag_r <= 1'b0;
		else if (restart)
			flag_r <= 1'b1;
		else if (we && idx == IDX_TSTAT && pstrb[0] && pwdata[TSTAT_FLAG_BIT])
			flag_r <= 1'b0;
	end

	// ----------------------------------------
	// channels
	// ----------------------------------------
	for (genvar g = 0; g < N_CH; g++) begin : g_ch
		dcpwm_chan u_chan (
			.clk_sys (clk_sys),
			.rst     (rst),
			.sleep   (sleep),
			.restart (restart),
			.base    (base_nxt),
			.period  (period_r),
			.wdata   (pwdata[15:0]),
			.duty_we ({2{we && idx == IDX_DUTY[g]}} & pstrb[1:0]),
			.ctl_we  (we && idx == IDX_CTRL[g] && pstrb[0]),
			.duty_rd (duty_rd[g]),
			.ctl_rd  (ctl_rd[g]),
			.level   (level[g])
		);
	end

	// ----------------------------------------
	// pin control and pin mux
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dir_r   <= PIN_DIR_RST;
			lat_r   <= PIN_LAT_RST;
			route_r <= ROUTE_RST;
		end else if (we && idx == IDX_PINCTL && pstrb[0]) begin
			dir_r   <= pwdata[PIN_DIR_LSB +: 2];
			lat_r   <= pwdata[PIN_LAT_LSB +: 2];
			route_r <= pwdata[PIN_ROUTE_LSB +: 2];
		end
	end

	// pins freeze in sleep so a driven level is held
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pin_oe_r  <= 2'b00;
			pin_out_r <= 2'b00;
			wave_r    <= 2'b00;
		end else if (!sleep) begin
			pin_oe_r  <= ~dir_r;
			pin_out_r <= (route_r & level) | (~route_r & lat_r);
			wave_r    <= level;
		end
	end

	assign pin_out  = pin_out_r;
	assign pin_oe   = pin_oe_r;
	assign wave_out = wave_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_wake;
		sleep ##1 !sleep;
	endsequence

	sequence s_ctrl_a_read;
		acc && !pready_r && !pwrite && aligned && idx == IDX_CTRL[0];
	endsequence

	chk_timer_frozen: assert property (sleep |=> $stable(cnt_r) && $stable(sub_r) && $stable(presc_r))
		else $error("timer moved during sleep");
	chk_pin_held: assert property (sleep |=> $stable(pin_out_r) && $stable(pin_oe_r))
		else $error("pin changed during sleep");
	chk_wake_resume: assert property (s_wake |-> cnt_r == $past(cnt_r) && sub_r == $past(sub_r))
		else $error("timer reloaded at wake");
	chk_fullrate_tick: assert property (on_r && presc_sel_r == 2'h0 && !sleep |-> tick)
		else $error("no tick at full rate");
	chk_base_step: assert property (tick && sub_r != SUB_MAX |=> sub_r == $past(sub_r) + 2'h1)
		else $error("time base skipped");
	chk_reset_pins: assert property (@(posedge clk_sys) disable iff (1'b0)
		rst |=> pin_oe_r == 2'b00 && dir_r == PIN_DIR_RST)
		else $error("pins not input after reset");
	chk_pin_dir: assert property (!sleep |=> pin_oe_r == ~$past(dir_r))
		else $error("pin enable does not follow direction");
	chk_pin_source: assert property (!sleep |=> pin_out_r ==
		(($past(route_r) & $past(level)) | (~$past(route_r) & $past(lat_r))))
		else $error("pin source wrong");
	chk_out_readback: assert property (s_ctrl_a_read |=> pready_r && prdata_r[CTL_OUT_BIT] == $past(level[0]))
		else $error("output level read back wrong");
	chk_flag_set_wins: assert property (restart |=> flag_r)
		else $error("overflow flag lost");
endmodule

// >>> dcpwm_sink.sv
// far-side model: the board net behind the two port pins
`timescale 1ns/1ns
module dcpwm_sink (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// pins from the unit
	input  wire logic [1:0] pin_out,
	input  wire logic [1:0] pin_oe,
	// resolved net level
	output logic      [1:0] net
);
	// no pull on the net: an undriven pin flips every cycle so a stale level never passes
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			net <= 2'h0;
		end else begin
			net <= (pin_oe & pin_out) | (~pin_oe & ~net);
		end
	end
endmodule

// >>> dcpwm_bench.sv
// self-checking bench for the dual channel pwm unit
`timescale 1ns/1ns
module dcpwm_bench;
	import dcpwm_pkg::*;
	logic        clk_sys = 1'h0;
	logic        rst     = 1'h1;
	logic        psel    = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite  = 1'h0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0;
	logic [3:0]  pstrb   = 4'hF;
	logic        sleep   = 1'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [1:0]  pin_out;
	logic [1:0]  pin_oe;
	logic [1:0]  wave_out;
	logic [1:0]  net;
	logic [31:0] rd;
	logic        err;
	int          failures = 0;
	int          n_tests  = 0;

	dcpwm_top #(.N_CH(2)) dcpwm_top_i (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sleep(sleep), .pin_out(pin_out), .pin_oe(pin_oe), .wave_out(wave_out));
	dcpwm_sink dcpwm_sink_i (.clk_sys(clk_sys), .rst(rst), .pin_out(pin_out), .pin_oe(pin_oe), .net(net));

	always #2 clk_sys = ~clk_sys;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic wrap_up;
		$display("counts: %0d compares, %0d mismatches", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one apb transfer; starts on a fresh edge so no signal is assigned twice in a step
	task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
		int n;
		@(posedge clk_sys);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= {idx, 2'h0};
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (pready !== 1'h1) begin
			failures++;
			wrap_up();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'h0;
			penable <= 1'h0;
		end
	endtask

	function automatic int exp_hi(int d, int per, int inv, int s, int n);
		int h;
		h = (d >= per) ? per : d;
		if (inv != 0) h = per - h;
		return h * s * n;
	endfunction

	// a window of whole periods sees the same high count whatever its phase
	task automatic run(input int p, input int ps, input int da, input int db, input int ia, input int ib);
		int per;
		int s;
		int ha;
		int hb;
		int n;
		per = 4 * (p + 1);
		s = 1 << (2 * ps);
		apb(1'h1, IDX_PINCTL, 32'h3);
		apb(1'h1, IDX_CTRL[0], 32'h0);
		apb(1'h1, IDX_CTRL[1], 32'h0);
		apb(1'h1, IDX_PERIOD, 32'(p));
		apb(1'h1, IDX_DUTY[0], 32'(da << DUTY_LO_LSB));
		apb(1'h1, IDX_DUTY[1], 32'(db << DUTY_LO_LSB));
		// channel b feeds only internal users, so its control may go in before the timer starts
		apb(1'h1, IDX_CTRL[1], 32'((1 << CTL_EN_BIT) | (ib << CTL_POL_BIT)));
		apb(1'h1, IDX_TSTAT, 32'(1 << TSTAT_FLAG_BIT));
		apb(1'h1, IDX_TCTL, 32'((1 << TCTL_ON_BIT) | ps));
		n = 0;
		do begin
			apb(1'h0, IDX_TSTAT, 32'h0);
			n++;
		end while (rd[TSTAT_FLAG_BIT] !== 1'h1 && n < 3000);
		if (rd[TSTAT_FLAG_BIT] !== 1'h1) begin
			failures++;
			wrap_up();
		end
		apb(1'h1, IDX_PINCTL, 32'h12);
		apb(1'h1, IDX_CTRL[0], 32'((1 << CTL_EN_BIT) | (ia << CTL_POL_BIT)));
		repeat (1100 * s) @(posedge clk_sys);
		ha = 0;
		hb = 0;
		repeat (3 * per * s) begin
			@(posedge clk_sys);
			ha += net[0];
			hb += wave_out[1];
		end
		check(32'(ha), 32'(exp_hi(da, per, ia, s, 3)));
		check(32'(hb), 32'(exp_hi(db, per, ib, s, 3)));
		$display("test run p=%0d ps=%0d duty=%0d/%0d done", p, ps, da, db);
	endtask

	initial begin
		repeat (90000) @(posedge clk_sys);
		failures++;
		wrap_up();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] dw;
		int          p;
		int          c;
		int          adv;
		void'($urandom(32'h2137CD97));
		repeat (2) @(posedge clk_sys);
		rst <= 1'h0;
		apb(1'h0, IDX_CTRL[0], 32'h0);
		check(rd, 32'h0);
		apb(1'h0, IDX_CTRL[1], 32'h0);
		check(rd, 32'h0);
		check(32'(pin_oe), 32'h0);
		apb(1'h0, IDX_PINCTL, 32'h0);
		check(rd, 32'h3);
		apb(1'h0, 10'h3FF, 32'h0);
		check(32'(err), 32'h1);
		dw = $urandom;
		apb(1'h1, IDX_DUTY[0], dw);
		apb(1'h0, IDX_DUTY[0], 32'h0);
		check(rd, dw & 32'hFFC0);
		apb(1'h1, IDX_CTRL[0], 32'h30);
		apb(1'h0, IDX_CTRL[0], 32'h0);
		check(rd, 32'h30);
		check(32'(wave_out[0]), 32'h1);
		apb(1'h1, IDX_PINCTL, 32'h6);
		repeat (3) @(posedge clk_sys);
		check(32'(net[0]), 32'h1);
		apb(1'h1, IDX_PINCTL, 32'h12);
		repeat (3) @(posedge clk_sys);
		check(32'(pin_oe), 32'h1);
		$display("test registers done");
		run(3, 0, 0, 16, 0, 0);
		run(7, 1, 31, 100, 1, 0);
		repeat (4) begin
			p = 2 + $urandom_range(0, 30);
			run(p, $urandom_range(0, 1), $urandom_range(0, 4 * p + 6), $urandom_range(0, 4 * p + 6),
				$urandom_range(0, 1), $urandom_range(0, 1));
		end
		run(9, 0, 13, 27, 0, 0);
		sleep <= 1'h1;
		repeat (3) @(posedge clk_sys);
		// the undriven pin toggles on its own, so only the driven one is held to its level
		dw = {29'h0, net[0], wave_out};
		apb(1'h0, IDX_TSTAT, 32'h0);
		c = int'(rd[15:8]);
		repeat (20) begin
			@(posedge clk_sys);
			check({29'h0, net[0], wave_out}, dw);
		end
		apb(1'h0, IDX_TSTAT, 32'h0);
		check(32'(rd[15:8]), 32'(c));
		@(posedge clk_sys);
		sleep <= 1'h0;
		repeat (8) @(posedge clk_sys);
		apb(1'h0, IDX_TSTAT, 32'h0);
		adv = (int'(rd[15:8]) - c + 10) % 10;
		check(32'(adv == 2 || adv == 3), 32'h1);
		$display("test sleep done");
		rst <= 1'h1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'h0;
		apb(1'h0, IDX_CTRL[0], 32'h0);
		check(rd, 32'h0);
		check(32'(pin_oe), 32'h0);
		check(32'(wave_out), 32'h0);
		apb(1'h0, IDX_DUTY[1], 32'h0);
		check(rd, 32'(27 << DUTY_LO_LSB));
		$display("test reset done");
		wrap_up();
	end
endmodule
